// File: core/annp_cfg.svh
`ifndef ANNP_CFG_SVH
`define ANNP_CFG_SVH

// Register word indices; byte address is four times the index
`define ANNP_IDX_STATUS 6'h06
`define ANNP_IDX_TX 6'h07
`define ANNP_IDX_RX 6'h08

// Word geometry
`define ANNP_WORD_W 16
`define ANNP_CODE_W 11
`define ANNP_STAT_PAGE_RX 1

// Reset values and alignment
`define ANNP_TX_RST 16'h2001
`define ANNP_RX_RST 16'h2001
`define ANNP_NULL_CODE 11'h001
`define ANNP_MP_RST 1'b1
`define ANNP_ZERO32 32'h0000_0000
`define ANNP_ALIGN 2'h0

`endif

// File: core/annp_pkg.sv
package annp_pkg;

    // Link code word as carried on the next-page exchange
    typedef struct packed {
        logic more_pages_flag;
        logic ack;
        logic message_page_select;
        logic comply_flag;
        logic toggle_echo;
        logic [10:0] code;
    } annp_word_type;

    // APB request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } annp_apb_req_type;

endpackage : annp_pkg

// File: core/annp_regs.sv
`timescale 1ns/1ns
`include "annp_cfg.svh"

module annp_regs
    import annp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic rx_page_valid_in,
    input wire annp_word_type rx_page_word_in,
    input wire logic tx_ack_in,
    input wire logic tx_page_sent_in,
    output annp_word_type next_page_word_out,
    output logic code_is_message_out,
    output logic page_received_out
);

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    annp_apb_req_type req;
    logic pready_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic setup_w;
    logic fire_w;
    logic aligned_w;
    logic [5:0] idx_w;
    logic hit_tx_w;
    logic hit_rx_w;
    logic hit_stat_w;
    logic wr_tx_w;
    logic rd_stat_w;

    assign req.psel = psel_in;
    assign req.penable = penable_in;
    assign req.pwrite = pwrite_in;
    assign req.paddr = paddr_in;
    assign req.pwdata = pwdata_in;

    // Answer in the first cycle of the access phase, one cycle after setup
    assign setup_w = req.psel & ~req.penable & ~pready_q;
    assign fire_w = req.psel & req.penable & pready_q;

    assign aligned_w = (req.paddr[1:0] == `ANNP_ALIGN);
    assign idx_w = req.paddr[7:2];
    assign hit_tx_w = aligned_w & (idx_w == `ANNP_IDX_TX);
    assign hit_rx_w = aligned_w & (idx_w == `ANNP_IDX_RX);
    assign hit_stat_w = aligned_w & (idx_w == `ANNP_IDX_STATUS);

    assign wr_tx_w = fire_w & req.pwrite & hit_tx_w;
    assign rd_stat_w = fire_w & ~req.pwrite & hit_stat_w;

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic np_q;
    logic ack_q;
    logic mp_q;
    logic comply_q;
    logic tog_q;
    logic [10:0] code_q;
    annp_word_type tx_word_w;
    annp_word_type wr_word_w;
    annp_word_type rx_q;
    logic page_rx_q;
    logic msg_q;

    assign wr_word_w = annp_word_type'(req.pwdata[`ANNP_WORD_W-1:0]);

    always_comb begin
        tx_word_w.more_pages_flag = np_q;
        tx_word_w.ack = ack_q;
        tx_word_w.message_page_select = mp_q;
        tx_word_w.comply_flag = comply_q;
        tx_word_w.toggle_echo = tog_q;
        tx_word_w.code = code_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outgoing word

    // Writes to bits 14 and 11 are dropped; hardware owns them
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {np_q, ack_q, mp_q, comply_q, tog_q, code_q} <= `ANNP_TX_RST;
        end else begin
            if (wr_tx_w) begin
                np_q <= wr_word_w.more_pages_flag;
                mp_q <= wr_word_w.message_page_select;
                comply_q <= wr_word_w.comply_flag;
                code_q <= wr_word_w.code;
            end
            ack_q <= tx_ack_in;
            if (tx_page_sent_in) begin
                tog_q <= ~tog_q;
            end
        end
    end

    // Code kind follows the stored message-page flag
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            msg_q <= `ANNP_MP_RST;
        end else begin
            msg_q <= mp_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Incoming word

    // Read-only to software; only a completed word changes it
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_q <= annp_word_type'(`ANNP_RX_RST);
        end else if (rx_page_valid_in) begin
            rx_q.more_pages_flag <= rx_page_word_in.more_pages_flag;
            rx_q.ack <= rx_page_word_in.ack;
            rx_q.message_page_select <= rx_page_word_in.message_page_select;
            rx_q.comply_flag <= rx_page_word_in.comply_flag;
            rx_q.toggle_echo <= ~rx_page_word_in.toggle_echo;
            rx_q.code <= rx_page_word_in.code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Page received, clear on read

    // A word landing on the clearing read keeps the flag set
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            page_rx_q <= 1'b0;
        end else if (rx_page_valid_in) begin
            page_rx_q <= 1'b1;
        end else if (rd_stat_w) begin
            page_rx_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    always_comb begin
        prdata_d = `ANNP_ZERO32;
        if (hit_tx_w) begin
            prdata_d[`ANNP_WORD_W-1:0] = tx_word_w;
        end else if (hit_rx_w) begin
            prdata_d[`ANNP_WORD_W-1:0] = rx_q;
        end else if (hit_stat_w) begin
            prdata_d[`ANNP_STAT_PAGE_RX] = page_rx_q;
        end
    end

    // Read data is sampled in setup; a word arriving in the access cycle
    // shows on the next read while the flag stays set
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_q <= 1'b0;
            prdata_q <= `ANNP_ZERO32;
            pslverr_q <= 1'b0;
        end else if (setup_w) begin
            pready_q <= 1'b1;
            prdata_q <= req.pwrite ? `ANNP_ZERO32 : prdata_d;
            pslverr_q <= ~(hit_tx_w | hit_rx_w | hit_stat_w);
        end else begin
            pready_q <= 1'b0;
            prdata_q <= `ANNP_ZERO32;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign next_page_word_out = tx_word_w;
    assign code_is_message_out = msg_q;
    assign page_received_out = page_rx_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic first_q;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_wr_tx;
        psel_in && penable_in && pready_out && pwrite_in && hit_tx_w;
    endsequence

    sequence s_rd_stat;
        psel_in && penable_in && pready_out && !pwrite_in && hit_stat_w;
    endsequence

    sequence s_rx_word;
        rx_page_valid_in;
    endsequence

    property p_np_write;
        s_wr_tx |=> next_page_word_out.more_pages_flag == $past(wr_word_w.more_pages_flag);
    endproperty
    a_np_write: assert property (p_np_write) else $error("more-pages write lost");

    property p_ack_hw;
        s_wr_tx |=> next_page_word_out.ack == $past(tx_ack_in);
    endproperty
    a_ack_hw: assert property (p_ack_hw) else $error("ack not hardware driven");

    property p_mp_write;
        s_wr_tx |=> next_page_word_out.message_page_select == $past(wr_word_w.message_page_select);
    endproperty
    a_mp_write: assert property (p_mp_write) else $error("message-page write lost");

    property p_comply_write;
        s_wr_tx |=> next_page_word_out.comply_flag == $past(wr_word_w.comply_flag);
    endproperty
    a_comply_write: assert property (p_comply_write) else $error("comply write lost");

    property p_toggle;
        tx_page_sent_in |=> next_page_word_out.toggle_echo != $past(next_page_word_out.toggle_echo);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle did not invert");

    property p_kind;
        ##1 code_is_message_out == $past(next_page_word_out.message_page_select);
    endproperty
    a_kind: assert property (p_kind) else $error("code kind wrong");

    property p_reset_vals;
        first_q |-> next_page_word_out == annp_word_type'(`ANNP_TX_RST)
            && !page_received_out && code_is_message_out;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

    property p_rx_capture;
        s_rx_word |=> rx_q.more_pages_flag == $past(rx_page_word_in.more_pages_flag)
            && rx_q.code == $past(rx_page_word_in.code);
    endproperty
    a_rx_capture: assert property (p_rx_capture) else $error("incoming word not captured");

    property p_rx_flags;
        s_rx_word |=> rx_q.ack == $past(rx_page_word_in.ack)
            && rx_q.message_page_select == $past(rx_page_word_in.message_page_select)
            && rx_q.comply_flag == $past(rx_page_word_in.comply_flag);
    endproperty
    a_rx_flags: assert property (p_rx_flags) else $error("incoming flags wrong");

    property p_rx_toggle;
        s_rx_word |=> rx_q.toggle_echo != $past(rx_page_word_in.toggle_echo);
    endproperty
    a_rx_toggle: assert property (p_rx_toggle) else $error("incoming toggle not inverted");

    property p_page_set;
        s_rx_word |=> page_received_out;
    endproperty
    a_page_set: assert property (p_page_set) else $error("page flag not set");

    property p_page_clear;
        s_rd_stat ##0 !rx_page_valid_in |=> !page_received_out;
    endproperty
    a_page_clear: assert property (p_page_clear) else $error("page flag not cleared");

    property p_rx_hold;
        !rx_page_valid_in |=> $stable(rx_q);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("incoming word changed alone");

    property p_bus_answer;
        psel_in && !penable_in && !pready_out |=> pready_out ##1 !pready_out;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

endmodule : annp_regs

// File: tb/annp_partner_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module annp_partner_model
    import annp_pkg::*;
(
    input wire logic ref_clk_in,
    output logic rx_page_valid_out,
    output annp_word_type rx_page_word_out,
    output logic tx_ack_out,
    output logic tx_page_sent_out
);
    initial begin
        rx_page_valid_out = 1'b0;
        rx_page_word_out = 16'h0000;
        tx_ack_out = 1'b0;
        tx_page_sent_out = 1'b0;
    end

    // Whole word in one pulse; bus shows a changed pattern after release
    task send_page(input logic [15:0] w);
        @(posedge ref_clk_in);
        rx_page_valid_out <= 1'b1;
        rx_page_word_out <= w;
        @(posedge ref_clk_in);
        rx_page_valid_out <= 1'b0;
        rx_page_word_out <= ~w;
    endtask : send_page

    task page_sent;
        @(posedge ref_clk_in);
        tx_page_sent_out <= 1'b1;
        @(posedge ref_clk_in);
        tx_page_sent_out <= 1'b0;
    endtask : page_sent

    task set_ack(input logic a);
        @(posedge ref_clk_in);
        tx_ack_out <= a;
    endtask : set_ack
endmodule : annp_partner_model

// File: tb/autoneg_next_page_regs_test.sv
`timescale 1ns/1ns
`include "annp_cfg.svh"
////////////////////////////////////////////////////////////
module autoneg_next_page_regs_test
    import annp_pkg::*;
;
    localparam logic [7:0] A_ST = {`ANNP_IDX_STATUS, `ANNP_ALIGN};
    localparam logic [7:0] A_TX = {`ANNP_IDX_TX, `ANNP_ALIGN};
    localparam logic [7:0] A_RX = {`ANNP_IDX_RX, `ANNP_ALIGN};
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, rx_valid, tx_ack, tx_sent, code_msg, page_rx;
    annp_word_type rx_word, np_word;
    int bad_count = 0;
    int check_count = 0;
    logic exp_tog = 1'b0;
    logic a;
    logic er;
    logic [31:0] rd;
    logic [15:0] w, last;

    always #2 ref_clk = ~ref_clk;

    annp_regs u_dut (.ref_clk_in(ref_clk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .rx_page_valid_in(rx_valid),
        .rx_page_word_in(rx_word), .tx_ack_in(tx_ack), .tx_page_sent_in(tx_sent),
        .next_page_word_out(np_word), .code_is_message_out(code_msg), .page_received_out(page_rx));

    annp_partner_model u_partner (.ref_clk_in(ref_clk), .rx_page_valid_out(rx_valid),
        .rx_page_word_out(rx_word), .tx_ack_out(tx_ack), .tx_page_sent_out(tx_sent));

    task end_sim;
        $display("mismatches %0d, checks %0d", bad_count, check_count);
        if (bad_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // Holds the request until pready is sampled high
    task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0000_0000);
        chk(rd, exp, "read data");
        chk(er, 1'b0, "read error");
    endtask : rd_chk

    function automatic logic [15:0] exp_out(input logic [15:0] d, input logic k, input logic t);
        return {d[15], k, d[13], d[12], t, d[10:0]};
    endfunction : exp_out

    initial begin
        #100000;
        chk(1'b0, 1'b1, "watchdog expired");
        end_sim;
    end

    initial begin
        void'($urandom(32'hdbb65570));
        repeat (6) @(posedge ref_clk);
        chk(np_word, `ANNP_TX_RST, "reset word");
        chk({code_msg, page_rx}, 2'b10, "reset flags");
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        rd_chk(A_TX, `ANNP_TX_RST);
        rd_chk(A_RX, `ANNP_RX_RST);
        rd_chk(A_ST, 32'h0000_0000);
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            a = (i == 0) ? 1'b1 : 1'($urandom);
            u_partner.set_ack(a);
            apb(1'b1, A_TX, {16'($urandom), w});
            if (i == 0 || $urandom % 2) begin
                u_partner.page_sent();
                exp_tog = ~exp_tog;
            end
            last = exp_out(w, a, exp_tog);
            rd_chk(A_TX, {16'h0000, last});
            chk(np_word, last, "outgoing word");
            chk(code_msg, w[13], "code kind");
        end
        apb(1'b1, A_RX, 32'h0000_ffff);
        chk(er, 1'b0, "incoming write error");
        apb(1'b1, A_TX + 8'h01, 32'h0000_5a5a);
        chk(er, 1'b1, "unaligned error");
        apb(1'b0, 8'h3c, 32'h0000_0000);
        chk(er, 1'b1, "unmapped error");
        chk(rd, 32'h0000_0000, "unmapped read");
        rd_chk(A_TX, {16'h0000, last});
        rd_chk(A_RX, `ANNP_RX_RST);
        for (int i = 0; i < 5; i++) begin
            w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            u_partner.send_page(w);
            #1;
            chk(page_rx, 1'b1, "page flag set");
            rd_chk(A_RX, {w[15:12], ~w[11], w[10:0]});
            apb(1'b0, A_ST, 32'h0000_0000);
            chk(rd[1], 1'b1, "status page bit");
            #1;
            chk(page_rx, 1'b0, "flag cleared by read");
            apb(1'b0, A_ST, 32'h0000_0000);
            chk(rd[1], 1'b0, "status after read");
        end
        // Mid-run reset must restore defaults
        @(posedge ref_clk);
        rstn <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(np_word, `ANNP_TX_RST, "second reset word");
        @(posedge ref_clk);
        rstn <= 1'b1;
        rd_chk(A_RX, `ANNP_RX_RST);
        end_sim;
    end
endmodule : autoneg_next_page_regs_test
